//--- verilog/scs_top.sv
/*
  Scan cycle supervisor: pads scans to a minimum time, flags overruns,
  rides through short supply dips.
  Assumes scan_done_in comes from logic on clk_in; supply and rack pins
  are asynchronous and are synchronised here.
*/
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module scs_top import scs_pkg::*; #(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [31:0] rd_data_out,
  // scan handshake
  input wire logic scan_done_in,
  output logic scan_start_out,
  // supply and rack pins
  input wire logic supply_ok_in,
  input wire logic legacy_rack_in,
  // status outputs
  output logic fatal_out,
  output logic power_fail_out,
  output logic periph_hold_out,
  output logic irq_out
);
  localparam int PW = $clog2(MS_CYCLES);
  localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYCLES - 1);

  // saturating range clamp, used by the minimum, limit and ride time writes
  function automatic logic [15:0] scs_clamp(input logic [31:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
    logic [15:0] r;
    r = v[15:0];
    if (|v[31:16] || v[15:0] > hi) begin
      r = hi;
    end else if (v[15:0] < lo) begin
      r = lo;
    end
    return r;
  endfunction

  // pin synchronisers
  logic [1:0] sup_sync_q, leg_sync_q;
  logic supply_bad, legacy_s;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sup_sync_q <= 2'b11;
      leg_sync_q <= 2'b00;
    end else begin
      sup_sync_q <= {sup_sync_q[0], supply_ok_in};
      leg_sync_q <= {leg_sync_q[0], legacy_rack_in};
    end
  end
  assign supply_bad = ~sup_sync_q[1];
  assign legacy_s = leg_sync_q[1];

  // settings registers
  scs_cfg_t cfg_q, cfg_d;
  logic [STATUS_W-1:0] mask_q, mask_d;
  logic wr_min, wr_max, wr_ride, wr_stat, wr_mask;
  always_comb begin
    wr_min = 1'b0;
    wr_max = 1'b0;
    wr_ride = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    if (wr_en_in && addr_in == OFS_MIN_CYCLE) begin
      wr_min = 1'b1;
    end else if (wr_en_in && addr_in == OFS_MAX_CYCLE) begin
      wr_max = 1'b1;
    end else if (wr_en_in && addr_in == OFS_RIDE_TIME) begin
      wr_ride = 1'b1;
    end else if (wr_en_in && addr_in == OFS_STATUS) begin
      wr_stat = 1'b1;
    end else if (wr_en_in && addr_in == OFS_MASK) begin
      wr_mask = 1'b1;
    end
  end

  // out-of-range writes saturate instead of being refused
  always_comb begin
    cfg_d = cfg_q;
    mask_d = mask_q;
    if (wr_min) begin
      cfg_d.min_ms = scs_clamp(wr_data_in, MIN_LO, MIN_HI);
    end
    if (wr_max) begin
      cfg_d.max_ms = scs_clamp(wr_data_in, MAX_LO, MAX_HI);
    end
    if (wr_ride) begin
      cfg_d.ride_ms = 4'(scs_clamp(wr_data_in, RIDE_LO, RIDE_HI));
    end
    if (wr_mask) begin
      mask_d = wr_data_in[STATUS_W-1:0];
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_q <= '{min_ms: MIN_RST, max_ms: MAX_RST, ride_ms: RIDE_RST};
      mask_q <= MASK_RST;
    end else begin
      cfg_q <= cfg_d;
      mask_q <= mask_d;
    end
  end

  // ride-through in force; legacy rack forces the default
  logic [3:0] ride_eff;
  assign ride_eff = legacy_s ? RIDE_RST : cfg_q.ride_ms;

  // scan sequencer with millisecond time base
  scs_state_t st_q, st_d;
  logic [PW-1:0] pre_q, pre_d;
  logic [15:0] ms_q, ms_d;
  logic start_q, start_d, fatal_q, fatal_d, tick;
  logic overrun_ev, pwr_fail_ev;
  assign tick = (pre_q == PRE_LAST);
  always_comb begin
    st_d = st_q;
    start_d = 1'b0;
    fatal_d = fatal_q;
    overrun_ev = 1'b0;
    case (st_q)
      ST_IDLE: begin
        start_d = 1'b1;
        st_d = ST_SCAN;
      end
      ST_SCAN: begin
        if (ms_q > cfg_q.max_ms) begin
          overrun_ev = 1'b1;
          fatal_d = 1'b1;
          st_d = ST_HALT;
        end else if (scan_done_in && ms_q >= cfg_q.min_ms) begin
          start_d = 1'b1;
        end else if (scan_done_in) begin
          st_d = ST_PAD;
        end
      end
      ST_PAD: begin
        // live setting compare, so a lowered minimum releases at once
        if (ms_q >= cfg_q.min_ms) begin
          start_d = 1'b1;
          st_d = ST_SCAN;
        end
      end
      ST_HALT: begin
        st_d = ST_HALT;
      end
      default: begin
        st_d = ST_HALT;
      end
    endcase
    if (pwr_fail_ev) begin
      start_d = 1'b0;
      st_d = ST_HALT;
    end
  end

  // counter restarts with every scan; resolution limits accuracy to 1 ms
  always_comb begin
    pre_d = tick ? '0 : pre_q + PW'(1);
    ms_d = ms_q;
    if (tick && ms_q != 16'hFFFF) begin
      ms_d = ms_q + 16'h0001;
    end
    if (start_d) begin
      pre_d = '0;
      ms_d = 16'h0000;
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= ST_IDLE;
      pre_q <= '0;
      ms_q <= 16'h0000;
      start_q <= 1'b0;
      fatal_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pre_q <= pre_d;
      ms_q <= ms_d;
      start_q <= start_d;
      fatal_q <= fatal_d;
    end
  end
  // interrupt programs only lengthen a scan; the pad never shortens for it

  // supply interruption timer
  logic [3:0] out_ms_q, out_ms_d;
  logic in_out_q, in_out_d, pfail_q, pfail_d, hold_q, hold_d, ridden_ev;
  always_comb begin
    out_ms_d = out_ms_q;
    in_out_d = in_out_q;
    pfail_d = pfail_q;
    pwr_fail_ev = 1'b0;
    ridden_ev = 1'b0;
    if (supply_bad && !pfail_q) begin
      in_out_d = 1'b1;
      if (out_ms_q >= ride_eff) begin
        pwr_fail_ev = 1'b1;
        pfail_d = 1'b1;
      end else if (tick) begin
        out_ms_d = out_ms_q + 4'h1;
      end
    end else if (!supply_bad && in_out_q) begin
      in_out_d = 1'b0;
      out_ms_d = 4'h0;
      ridden_ev = !pfail_q;
    end
    // peripheral service paused while riding through a dip
    hold_d = supply_bad && !pfail_q && ride_eff != 4'h0;
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      out_ms_q <= 4'h0;
      in_out_q <= 1'b0;
      pfail_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      out_ms_q <= out_ms_d;
      in_out_q <= in_out_d;
      pfail_q <= pfail_d;
      hold_q <= hold_d;
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  logic [STATUS_W-1:0] stat_q, stat_d, ev;
  logic irq_q, irq_d, too_long_q, too_long_d;
  always_comb begin
    ev = '0;
    ev[ST_OVERRUN_BIT] = overrun_ev;
    ev[ST_PWRFAIL_BIT] = pwr_fail_ev;
    ev[ST_RIDDEN_BIT] = ridden_ev;
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~wr_data_in[STATUS_W-1:0];
    end
    stat_d = stat_d | ev;
    irq_d = |(stat_d & mask_d);
    // aux flag is cleared only by reset, like the fatal state
    too_long_d = too_long_q | overrun_ev;
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stat_q <= '0;
      irq_q <= 1'b0;
      too_long_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q <= irq_d;
      too_long_q <= too_long_d;
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  logic [31:0] rd_q, rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    if (rd_en_in && addr_in == OFS_MIN_CYCLE) begin
      rd_d[15:0] = cfg_q.min_ms;
    end else if (rd_en_in && addr_in == OFS_MAX_CYCLE) begin
      rd_d[15:0] = cfg_q.max_ms;
    end else if (rd_en_in && addr_in == OFS_RIDE_TIME) begin
      rd_d[3:0] = cfg_q.ride_ms;
    end else if (rd_en_in && addr_in == OFS_STATUS) begin
      rd_d[STATUS_W-1:0] = stat_q;
    end else if (rd_en_in && addr_in == OFS_MASK) begin
      rd_d[STATUS_W-1:0] = mask_q;
    end else if (rd_en_in && addr_in == OFS_STATE) begin
      rd_d[15:0] = ms_q;
      rd_d[STATE_FSM_LSB+3:STATE_FSM_LSB] = st_q;
    end else if (rd_en_in && addr_in == OFS_AUX) begin
      rd_d[AUX_TOO_LONG_BIT] = too_long_q;
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_q <= 32'h0000_0000;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data_out = rd_q;
  assign scan_start_out = start_q;
  assign fatal_out = fatal_q;
  assign power_fail_out = pfail_q;
  assign periph_hold_out = hold_q;
  assign irq_out = irq_q;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_early_done;
    st_q == ST_SCAN && scan_done_in && ms_q < cfg_q.min_ms
      && ms_q <= cfg_q.max_ms && !pwr_fail_ev;
  endsequence
  sequence s_short_dip;
    supply_bad && !pfail_q && out_ms_q < ride_eff && !tick ##1 !supply_bad;
  endsequence

  AST_PAD_HOLD: assert property (s_early_done |=> st_q == ST_PAD
    && !scan_start_out) else $error("early scan not padded");
  AST_NO_WAIT: assert property (st_q == ST_SCAN && scan_done_in
    && ms_q >= cfg_q.min_ms && ms_q <= cfg_q.max_ms && !pwr_fail_ev
    |=> scan_start_out && ms_q == 16'h0000)
    else $error("late scan did not restart at once");
  AST_FIRST_SCAN: assert property (st_q == ST_IDLE |=> scan_start_out
    && st_q == ST_SCAN) else $error("no scan after reset");
  AST_OVERRUN: assert property (st_q == ST_SCAN && ms_q > cfg_q.max_ms
    |=> fatal_out && too_long_q && st_q == ST_HALT && !scan_start_out)
    else $error("overrun not flagged");
  AST_FATAL_STAYS: assert property (fatal_out |=> fatal_out
    && st_q == ST_HALT) else $error("fatal state left");
  AST_MS_RESTART: assert property (scan_start_out |-> ms_q == 16'h0000
    && pre_q == '0) else $error("scan counter not restarted");
  AST_MS_STEP: assert property (tick && !start_d && ms_q != 16'hFFFF
    |=> ms_q == $past(ms_q) + 16'h0001) else $error("ms count wrong");
  AST_MIN_RANGE: assert property (cfg_q.min_ms <= MIN_HI)
    else $error("minimum out of range");
  AST_MAX_RANGE: assert property (cfg_q.max_ms >= MAX_LO
    && cfg_q.max_ms <= MAX_HI) else $error("limit out of range");
  AST_RIDE_RANGE: assert property (cfg_q.ride_ms <= 4'(RIDE_HI))
    else $error("ride time out of range");
  AST_MIN_NOW: assert property (wr_min && wr_data_in <= 32'(MIN_HI)
    |=> cfg_q.min_ms == $past(wr_data_in[15:0]))
    else $error("minimum write not applied");
  AST_MAX_NOW: assert property (wr_max && wr_data_in >= 32'(MAX_LO)
    && wr_data_in <= 32'(MAX_HI) |=> cfg_q.max_ms == $past(wr_data_in[15:0]))
    else $error("limit write not applied");
  AST_RIDE_NOW: assert property (wr_ride && wr_data_in <= 32'(RIDE_HI)
    |=> cfg_q.ride_ms == $past(wr_data_in[3:0]))
    else $error("ride write not applied");
  AST_RIDE_OK: assert property (!pfail_q throughout s_short_dip
    |=> !power_fail_out) else $error("short dip became power fail");
  AST_LEGACY: assert property (legacy_s && supply_bad
    |=> power_fail_out) else $error("legacy dip not failed at once");
  AST_HOLD: assert property (hold_q |-> ride_eff != 4'h0 ||
    $past(ride_eff) != 4'h0) else $error("hold with zero ride time");
endmodule

//--- verilog/scs_pkg.sv
/*
  Constants, register map and carrier types of the scan cycle supervisor.
  Assumes a single 100 MHz clock and a plain strobe register port.
*/
package scs_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES_DFLT = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFS_MIN_CYCLE = 8'h00;
  localparam logic [7:0] OFS_MAX_CYCLE = 8'h04;
  localparam logic [7:0] OFS_RIDE_TIME = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;
  localparam logic [7:0] OFS_AUX = 8'h18;

  // setting limits, milliseconds
  localparam logic [15:0] MIN_LO = 16'h0000;
  localparam logic [15:0] MIN_HI = 16'h7D00;   // 32,000
  localparam logic [15:0] MAX_LO = 16'h000A;   // 10
  localparam logic [15:0] MAX_HI = 16'h9C40;   // 40,000
  localparam logic [15:0] RIDE_LO = 16'h0000;
  localparam logic [15:0] RIDE_HI = 16'h000A;  // 10

  // reset values
  localparam logic [15:0] MIN_RST = 16'h0000;  // variable cycle
  localparam logic [15:0] MAX_RST = 16'h03E8;  // 1,000
  localparam logic [3:0] RIDE_RST = 4'h0;
  localparam logic [2:0] MASK_RST = 3'h0;

  // status and aux field positions
  localparam int ST_OVERRUN_BIT = 0;
  localparam int ST_PWRFAIL_BIT = 1;
  localparam int ST_RIDDEN_BIT = 2;
  localparam int STATUS_W = 3;
  localparam int AUX_TOO_LONG_BIT = 8;
  localparam int STATE_FSM_LSB = 16;

  // settings carrier
  typedef struct packed {
    logic [15:0] min_ms;
    logic [15:0] max_ms;
    logic [3:0] ride_ms;
  } scs_cfg_t;

  // scan sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SCAN = 4'b0010,
    ST_PAD = 4'b0100,
    ST_HALT = 4'b1000
  } scs_state_t;
endpackage

//--- verif/scs_top_bench.sv
/*
  Self-checking bench for the scan cycle supervisor.
  Assumes scs_pkg and scs_top are compiled first; the bench plays the
  register master, the scan logic and the supply and rack pins itself.
*/
`timescale 1ns/1ps
module scs_top_bench import scs_pkg::*; ;
  // short millisecond keeps the run small; the ms figures scale from it, the 400 and 300 cycle wait limits do not
  localparam int MS = 10;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0000_0000;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic scan_done_in = 1'b0;
  logic supply_ok_in = 1'b1;
  logic legacy_rack_in = 1'b0;
  logic [31:0] rd_data_out;
  logic scan_start_out;
  logic fatal_out;
  logic power_fail_out;
  logic periph_hold_out;
  logic irq_out;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] rd_word;
  int n;

  scs_top #(.MS_CYCLES(MS)) u_dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .scan_done_in(scan_done_in),
    .scan_start_out(scan_start_out), .supply_ok_in(supply_ok_in),
    .legacy_rack_in(legacy_rack_in), .fatal_out(fatal_out),
    .power_fail_out(power_fail_out), .periph_hold_out(periph_hold_out),
    .irq_out(irq_out));

  // 100 MHz clock
  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // verdict, reached from the main sequence or a spent wait
  task automatic complete_run();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // compare tasks
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h", $time, what, got);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %b", $time, what, got);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi,
                         input string what);
    samples_checked++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("CHECK FAILED %0t %s took %0d cycles", $time, what, got);
    end
  endtask

  // register master: one-cycle strobes, read data in the next cycle
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1;
    d = rd_data_out;
  endtask

  // scan logic stand-in
  task automatic pulse_done();
    @(posedge clk_in);
    scan_done_in <= 1'b1;
    @(posedge clk_in);
    scan_done_in <= 1'b0;
  endtask
  // entered on an edge; counts cycles until a start pulse is seen
  task automatic wait_start(input int lim, output int cnt);
    cnt = 0;
    #1;
    while (scan_start_out !== 1'b1) begin
      if (cnt >= lim) begin
        fail_count++;
        $display("CHECK FAILED %0t no scan start", $time);
        complete_run();
      end
      @(posedge clk_in);
      #1;
      cnt++;
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk_in);
  endtask

  task automatic do_reset();
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    supply_ok_in <= 1'b1;
    legacy_rack_in <= 1'b0;
    scan_done_in <= 1'b0;
    idle(16);
    arst_n_in <= 1'b1;
    idle(1);
    wait_start(4, n);
  endtask

  // scenarios
  task automatic t_defaults();
    reg_rd(OFS_MIN_CYCLE, rd_word);
    chk_val(rd_word, 32'h0000_0000, "min reset");
    reg_rd(OFS_MAX_CYCLE, rd_word);
    chk_val(rd_word, 32'h0000_03E8, "max reset");
    reg_rd(OFS_RIDE_TIME, rd_word);
    chk_val(rd_word, 32'h0000_0000, "ride reset");
    reg_rd(8'h40, rd_word);
    chk_val(rd_word, 32'h0000_0000, "unmapped read");
  endtask
  task automatic t_variable();
    repeat (2) begin
      pulse_done();
      wait_start(4, n);
      chk_rng(n, 0, 1, "variable cycle restart");
    end
  endtask
  task automatic t_limits();
    reg_wr(OFS_MIN_CYCLE, 32'h0000_FFFF);
    reg_rd(OFS_MIN_CYCLE, rd_word);
    chk_val(rd_word, 32'h0000_7D00, "min ceiling");
    reg_wr(OFS_MAX_CYCLE, 32'h0000_0005);
    reg_rd(OFS_MAX_CYCLE, rd_word);
    chk_val(rd_word, 32'h0000_000A, "max floor");
    reg_wr(OFS_MAX_CYCLE, 32'h0001_0000);
    reg_rd(OFS_MAX_CYCLE, rd_word);
    chk_val(rd_word, 32'h0000_9C40, "max ceiling");
    reg_wr(OFS_RIDE_TIME, 32'h0000_000F);
    reg_rd(OFS_RIDE_TIME, rd_word);
    chk_val(rd_word, 32'h0000_000A, "ride ceiling");
    reg_wr(OFS_MAX_CYCLE, 32'h0000_03E8);
    reg_wr(OFS_RIDE_TIME, 32'h0000_0000);
    reg_wr(OFS_MIN_CYCLE, 32'h0000_0014);
  endtask
  // minimum of 20 ms, with a few ms of slack either way
  task automatic t_pad();
    pulse_done();
    wait_start(400, n);
    pulse_done();
    wait_start(400, n);
    chk_rng(n + 2, 16 * MS, 24 * MS + 5, "padded period");
  endtask
  task automatic t_late();
    idle(25 * MS);
    pulse_done();
    wait_start(4, n);
    chk_rng(n, 0, 2, "long scan restart");
  endtask
  task automatic t_live();
    pulse_done();
    idle(2 * MS);
    reg_wr(OFS_MIN_CYCLE, 32'h0000_0000);
    wait_start(6, n);
    chk_rng(n, 0, 3, "min cleared in pad");
  endtask
  // dip of 3 ms against a 5 ms ride time
  task automatic t_dip();
    reg_wr(OFS_MASK, 32'h0000_0004);
    reg_rd(OFS_MASK, rd_word);
    chk_val(rd_word, 32'h0000_0004, "mask readback");
    reg_wr(OFS_RIDE_TIME, 32'h0000_0005);
    supply_ok_in <= 1'b0;
    idle(MS);
    #1;
    chk_bit(periph_hold_out, 1'b1, "peripheral hold");
    idle(2 * MS);
    supply_ok_in <= 1'b1;
    idle(6);
    #1;
    chk_bit(power_fail_out, 1'b0, "dip ridden");
    chk_bit(periph_hold_out, 1'b0, "hold released");
    reg_rd(OFS_STATUS, rd_word);
    chk_val(rd_word, 32'h0000_0004, "ridden status");
    chk_bit(irq_out, 1'b1, "irq raised");
    reg_wr(OFS_STATUS, 32'h0000_0004);
    idle(2);
    #1;
    chk_bit(irq_out, 1'b0, "irq cleared");
  endtask
  // legacy rack forces the default ride time of zero
  task automatic t_legacy();
    reg_wr(OFS_RIDE_TIME, 32'h0000_000A);
    legacy_rack_in <= 1'b1;
    idle(4);
    supply_ok_in <= 1'b0;
    idle(8);
    #1;
    chk_bit(power_fail_out, 1'b1, "legacy fail");
    reg_rd(OFS_STATUS, rd_word);
    chk_bit(rd_word[ST_PWRFAIL_BIT], 1'b1, "fail status");
    do_reset();
  endtask
  task automatic t_overrun();
    reg_wr(OFS_MASK, 32'h0000_0001);
    reg_wr(OFS_MAX_CYCLE, 32'h0000_000A);
    pulse_done();
    wait_start(4, n);
    n = 0;
    while (fatal_out !== 1'b1) begin
      if (n >= 300) begin
        fail_count++;
        $display("CHECK FAILED %0t no overrun", $time);
        complete_run();
      end
      @(posedge clk_in);
      #1;
      n++;
    end
    chk_rng(n, 10 * MS, 12 * MS + 5, "overrun time");
    reg_rd(OFS_AUX, rd_word);
    chk_bit(rd_word[AUX_TOO_LONG_BIT], 1'b1, "too long flag");
    reg_rd(OFS_STATUS, rd_word);
    chk_bit(rd_word[ST_OVERRUN_BIT], 1'b1, "overrun status");
    chk_bit(irq_out, 1'b1, "overrun irq");
    reg_rd(OFS_STATE, rd_word);
    chk_val(rd_word & 32'h000F_0000, 32'h0008_0000, "halted state");
  endtask

  // main sequence
  initial begin
    do_reset();
    t_defaults();
    t_variable();
    t_limits();
    t_pad();
    t_late();
    t_live();
    t_dip();
    t_legacy();
    t_overrun();
    complete_run();
  end
endmodule
